// ==== src/sbd_core.sv ====
// Execute unit for system control, flags, bit and block-copy instructions
// Summary of operation
// - Software trap saves state and jumps into the trap vector area.
// - Exception return restores saved program counter and flags.
// - Sleep instruction enters the power-down state.
// - Load-flags copies source into flags; memory source read as a word.
// - Store-flags copies flags out; memory destination written as a word.
// - Flags AND immediate byte replaces the flags.
// - Flags OR immediate byte replaces the flags.
// - Flags XOR immediate byte replaces the flags.
// - No-operation only advances the program counter by two.
// - Block copy uses register 4 count, 5 source, 6 destination.
// - Copy byte, bump both pointers, decrement count until zero; zero copies nothing.
// - Next instruction is fetched as soon as the copy ends.
// - Instructions are whole 16-bit words, extensions fetched as words.
// - Operation field is always the first four bits.
// - Address registers use three bits, data registers three or four.
// - Extensions are 16 or 32 bits; 24-bit values drop top byte.
// - Condition field is decoded only for conditional branches.
// - Bit set, clear, invert and carry stores read, modify, write a byte.
// - Branch taken only when its selected flag condition holds.
`timescale 1ns/10ps
module sbd_core #(
  parameter int REG_COUNT = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_byte_o,
  output logic [sbd_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [sbd_pkg::DATA_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [sbd_pkg::DATA_W-1:0] mem_rdata_i,
  input wire logic wake_i,
  output logic sleeping_o,
  output logic [sbd_pkg::FLAG_W-1:0] flags_o,
  output logic [sbd_pkg::ADDR_W-1:0] pc_o
);
  import sbd_pkg::*;

  if (REG_COUNT != 8) begin : g_bad_count
    $error("REG_COUNT must be 8");
  end

  logic rst_meta_n;
  logic rst_n;
  logic wake_meta;
  logic wake_s;
  sbd_state_t state;
  sbd_state_t next_state;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic [31:0] ext;
  logic [31:0] next_ext;
  logic [1:0] ext_cnt;
  logic [1:0] next_ext_cnt;
  logic [23:0] pc;
  logic [23:0] next_pc;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [23:0] saved_pc;
  logic [23:0] next_saved_pc;
  logic [7:0] saved_flags;
  logic [7:0] next_saved_flags;
  logic [23:0] ea;
  logic [23:0] next_ea;
  logic [15:0] mdata;
  logic [15:0] next_mdata;
  logic blk_word;
  logic next_blk_word;
  logic reg_we;
  logic [2:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic blk_step;
  logic [31:0] regs [REG_COUNT];
  logic [31:0] reg_next [REG_COUNT];
  logic [23:0] next_bus_addr;
  logic next_bus_we;
  logic next_bus_byte;

  sbd_dec_if dif ();
  sbd_field_decode u_dec (
    .d(dif.dec)
  );
  assign dif.instr = ir;
  assign dif.flags = flags;

  // Release of reset and wake pin through two flip-flops each
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta <= 1'b0;
      wake_s <= 1'b0;
    end else begin
      wake_meta <= wake_i;
      wake_s <= wake_meta;
    end
  end

  // Operand selection
  wire [7:0] rd_full = regs[dif.reg_d[2:0]][7:0];
  wire [7:0] rd_high = regs[dif.reg_d[2:0]][15:8];
  wire [7:0] data_byte = dif.reg_d[3] ? rd_high : rd_full;
  wire [31:0] rd_word = regs[dif.reg_d[2:0]];
  wire [31:0] byte_merged = dif.reg_d[3] ? {rd_word[31:16], flags, rd_word[7:0]} :
                                           {rd_word[31:8], flags};
  wire [23:0] areg = regs[dif.reg_a][23:0];
  wire [15:0] blk_cnt = blk_word ? regs[BLK_CNT_REG][15:0] : {8'h00, regs[BLK_CNT_REG][7:0]};
  wire [15:0] dec_cnt = dif.block_word ? regs[BLK_CNT_REG][15:0] :
                                         {8'h00, regs[BLK_CNT_REG][7:0]};
  wire [23:0] disp = dif.branch_long ? {{8{ext[15]}}, ext[15:0]} : {{16{ir[7]}}, ir[7:0]};
  wire [23:0] trap_target = TRAP_BASE + {20'h00000, dif.trap_vec, 2'h0};

  // single-bit modify of the fetched byte
  wire [7:0] bit_mask = 8'h01 << dif.bit_num;
  wire store_one = flags[FLAG_C] ^ dif.bit_inv;
  wire [7:0] rmw_in = mem_rdata_i[7:0];
  wire [7:0] rmw_set = rmw_in | bit_mask;
  wire [7:0] rmw_clr = rmw_in & ~bit_mask;
  wire [7:0] rmw_out = (dif.bit_kind == BIT_SET) ? rmw_set :
                       (dif.bit_kind == BIT_CLEAR) ? rmw_clr :
                       (dif.bit_kind == BIT_INVERT) ? (rmw_in ^ bit_mask) :
                       (store_one ? rmw_set : rmw_clr);

  wire [7:0] flag_logic = (dif.logic_op == 2'h0) ? (flags & dif.imm8) :
                          (dif.logic_op == 2'h1) ? (flags | dif.imm8) : (flags ^ dif.imm8);

  // Register file: general write port plus block pointer updates
  generate
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      localparam logic [2:0] IDX = 3'(g);
      logic [31:0] blk_val;
      if (g == BLK_CNT_REG) begin : g_cnt
        assign blk_val = blk_word ? {regs[g][31:16], regs[g][15:0] - 16'h0001} :
                                    {regs[g][31:8], regs[g][7:0] - 8'h01};
      end else if (g == BLK_SRC_REG || g == BLK_DST_REG) begin : g_ptr
        assign blk_val = regs[g] + 32'h00000001;
      end else begin : g_keep
        assign blk_val = regs[g];
      end
      assign reg_next[g] = blk_step ? blk_val :
                           (reg_we && reg_waddr == IDX) ? reg_wdata : regs[g];
      always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          regs[g] <= 32'h00000000;
        end else begin
          regs[g] <= reg_next[g];
        end
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_ir = ir;
    next_ext = ext;
    next_ext_cnt = ext_cnt;
    next_pc = pc;
    next_flags = flags;
    next_saved_pc = saved_pc;
    next_saved_flags = saved_flags;
    next_ea = ea;
    next_mdata = mdata;
    next_blk_word = blk_word;
    reg_we = 1'b0;
    reg_waddr = 3'h0;
    reg_wdata = 32'h00000000;
    blk_step = 1'b0;
    case (state)
      ST_FETCH: begin
        if (mem_ack_i) begin
          next_ir = mem_rdata_i;
          next_pc = pc + PC_STEP;
          next_state = ST_DEC;
        end
      end
      ST_DEC: begin
        next_ext = 32'h00000000;
        next_ext_cnt = dif.ext_words;
        next_state = (dif.ext_words != 2'h0) ? ST_EXT : ST_EXEC;
      end
      ST_EXT: begin
        if (mem_ack_i) begin
          next_ext = {ext[15:0], mem_rdata_i};
          next_pc = pc + PC_STEP;
          next_ext_cnt = ext_cnt - 2'h1;
          if (ext_cnt == 2'h1) begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_state = ST_FETCH;
        case (dif.kind)
          K_TRAP, K_ILLEGAL: begin
            next_saved_pc = pc;
            next_saved_flags = flags;
            next_flags[FLAG_I] = 1'b1;
            next_pc = trap_target;
          end
          K_RETURN: begin
            next_pc = saved_pc;
            next_flags = saved_flags;
          end
          K_SLEEP: next_state = ST_SLEEP;
          K_FLAG_LOGIC: next_flags = flag_logic;
          K_LDF_REG: next_flags = data_byte;
          K_STF_REG: begin
            reg_we = 1'b1;
            reg_waddr = dif.reg_d[2:0];
            reg_wdata = byte_merged;
          end
          K_LDF_MEM: begin
            next_ea = {areg[23:1], 1'b0};
            next_state = ST_MRD;
          end
          // 24-bit address from a 32-bit extension
          K_LDF_ABS: begin
            next_ea = {ext[23:1], 1'b0};
            next_state = ST_MRD;
          end
          K_STF_MEM: begin
            next_ea = {areg[23:1], 1'b0};
            next_mdata = {8'h00, flags};
            next_state = ST_MWR;
          end
          K_BLOCK: begin
            next_blk_word = dif.block_word;
            next_state = (dec_cnt == 16'h0000) ? ST_FETCH : ST_BRD;
          end
          K_BRANCH: begin
            if (dif.branch_take) begin
              next_pc = pc + disp;
            end
          end
          K_BITOP: begin
            next_ea = areg;
            next_state = ST_MRD;
          end
          default: next_state = ST_FETCH;
        endcase
      end
      ST_MRD: begin
        if (mem_ack_i) begin
          if (dif.kind == K_BITOP) begin
            next_mdata = {8'h00, rmw_out};
            next_state = ST_MWR;
          end else begin
            next_flags = mem_rdata_i[7:0];
            next_state = ST_FETCH;
          end
        end
      end
      ST_MWR: begin
        if (mem_ack_i) begin
          next_state = ST_FETCH;
        end
      end
      ST_BRD: begin
        if (mem_ack_i) begin
          next_mdata = {8'h00, mem_rdata_i[7:0]};
          next_state = ST_BWR;
        end
      end
      ST_BWR: begin
        // step pointers, end straight into fetch
        if (mem_ack_i) begin
          blk_step = 1'b1;
          next_state = (blk_cnt == 16'h0001) ? ST_FETCH : ST_BRD;
        end
      end
      ST_SLEEP: begin
        if (wake_s) begin
          next_state = ST_FETCH;
        end
      end
      default: next_state = ST_FETCH;
    endcase
  end

  // Bus address and kind follow the state being entered, so they are stable with the request
  always_comb begin
    next_bus_addr = next_pc;
    next_bus_we = 1'b0;
    next_bus_byte = 1'b0;
    case (next_state)
      ST_MRD: begin
        next_bus_addr = next_ea;
        next_bus_byte = (dif.kind == K_BITOP);
      end
      ST_MWR: begin
        next_bus_addr = next_ea;
        next_bus_we = 1'b1;
        next_bus_byte = (dif.kind == K_BITOP);
      end
      ST_BRD: begin
        next_bus_addr = reg_next[BLK_SRC_REG][23:0];
        next_bus_byte = 1'b1;
      end
      ST_BWR: begin
        next_bus_addr = reg_next[BLK_DST_REG][23:0];
        next_bus_we = 1'b1;
        next_bus_byte = 1'b1;
      end
      default: next_bus_addr = next_pc;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_FETCH;
      ir <= 16'h0000;
      ext <= 32'h00000000;
      ext_cnt <= 2'h0;
      pc <= RESET_PC;
      flags <= FLAGS_RESET;
      saved_pc <= RESET_PC;
      saved_flags <= FLAGS_RESET;
      ea <= 24'h000000;
      mdata <= 16'h0000;
      blk_word <= 1'b0;
      mem_addr_o <= RESET_PC;
      mem_we_o <= 1'b0;
      mem_byte_o <= 1'b0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      ext <= next_ext;
      ext_cnt <= next_ext_cnt;
      pc <= next_pc;
      flags <= next_flags;
      saved_pc <= next_saved_pc;
      saved_flags <= next_saved_flags;
      ea <= next_ea;
      mdata <= next_mdata;
      blk_word <= next_blk_word;
      mem_addr_o <= next_bus_addr;
      mem_we_o <= next_bus_we;
      mem_byte_o <= next_bus_byte;
    end
  end

  assign mem_req_o = (state == ST_FETCH) || (state == ST_EXT) || (state == ST_MRD) ||
                     (state == ST_MWR) || (state == ST_BRD) || (state == ST_BWR);
  assign mem_wdata_o = mdata;
  assign sleeping_o = (state == ST_SLEEP);
  assign flags_o = flags;
  assign pc_o = pc;
endmodule

// ==== pkg/sbd_pkg.sv ====
// Constants, encodings and types for the system-control and block-copy execute unit
package sbd_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int FLAG_W = 8;
  localparam int XREG_W = 32;
  // Instruction field positions
  localparam int OPF_HI = 15;
  localparam int OPF_LO = 12;
  localparam int SUB_HI = 11;
  localparam int SUB_LO = 8;
  localparam int RA_HI = 6;
  localparam int RA_LO = 4;
  localparam int RD_HI = 3;
  localparam int RD_LO = 0;
  localparam int BK_HI = 11;
  localparam int BK_LO = 10;
  localparam int BINV_POS = 9;
  localparam int BNUM_HI = 2;
  localparam int BNUM_LO = 0;
  localparam int VEC_HI = 5;
  localparam int VEC_LO = 4;
  // Major operation codes (first field)
  localparam logic [3:0] OPC_SYS = 4'h0;
  localparam logic [3:0] OPC_BRANCH8 = 4'h4;
  localparam logic [3:0] OPC_BRANCH16 = 4'h5;
  localparam logic [3:0] OPC_BITOP = 4'h7;
  // Second operation field of the system group
  localparam logic [3:0] SUB_NO_OP = 4'h0;
  localparam logic [3:0] SUB_TRAP = 4'h1;
  localparam logic [3:0] SUB_RETURN = 4'h2;
  localparam logic [3:0] SUB_SLEEP = 4'h3;
  localparam logic [3:0] SUB_FLAGS_AND = 4'h4;
  localparam logic [3:0] SUB_FLAGS_OR = 4'h5;
  localparam logic [3:0] SUB_FLAGS_XOR = 4'h6;
  localparam logic [3:0] SUB_LDF_REG = 4'h7;
  localparam logic [3:0] SUB_STF_REG = 4'h8;
  localparam logic [3:0] SUB_LDF_MEM = 4'h9;
  localparam logic [3:0] SUB_STF_MEM = 4'hA;
  localparam logic [3:0] SUB_BLK_BYTE = 4'hB;
  localparam logic [3:0] SUB_BLK_WORD = 4'hC;
  localparam logic [3:0] SUB_LDF_ABS = 4'hD;
  // Bit operation kinds
  localparam logic [1:0] BIT_SET = 2'h0;
  localparam logic [1:0] BIT_CLEAR = 2'h1;
  localparam logic [1:0] BIT_INVERT = 2'h2;
  localparam logic [1:0] BIT_CARRY = 2'h3;
  // Flags register layout and reset value
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  // Program counter start and trap vector area
  localparam logic [23:0] RESET_PC = 24'h000100;
  localparam logic [23:0] TRAP_BASE = 24'h000020;
  localparam logic [23:0] PC_STEP = 24'h000002;
  // Block copy register assignment
  localparam logic [2:0] BLK_CNT_REG = 3'h4;
  localparam logic [2:0] BLK_SRC_REG = 3'h5;
  localparam logic [2:0] BLK_DST_REG = 3'h6;
  localparam logic [1:0] EXT_ABS_WORDS = 2'h2;
  localparam logic [1:0] EXT_DISP_WORDS = 2'h1;

  typedef enum logic [3:0] {
    K_NO_OP = 4'h0,
    K_TRAP = 4'h1,
    K_RETURN = 4'h2,
    K_SLEEP = 4'h3,
    K_FLAG_LOGIC = 4'h4,
    K_LDF_REG = 4'h5,
    K_STF_REG = 4'h6,
    K_LDF_MEM = 4'h7,
    K_STF_MEM = 4'h8,
    K_LDF_ABS = 4'h9,
    K_BLOCK = 4'hA,
    K_BRANCH = 4'hB,
    K_BITOP = 4'hC,
    K_ILLEGAL = 4'hD
  } sbd_kind_t;

  typedef enum logic [8:0] {
    ST_FETCH = 9'h001,
    ST_DEC = 9'h002,
    ST_EXT = 9'h004,
    ST_EXEC = 9'h008,
    ST_MRD = 9'h010,
    ST_MWR = 9'h020,
    ST_BRD = 9'h040,
    ST_BWR = 9'h080,
    ST_SLEEP = 9'h100
  } sbd_state_t;
endpackage

// ==== pkg/sbd_dec_if.sv ====
// Carrier between the execute unit and its field decoder
`timescale 1ns/10ps
interface sbd_dec_if;
  import sbd_pkg::*;
  logic [15:0] instr;
  logic [7:0] flags;
  sbd_kind_t kind;
  logic [2:0] reg_a;
  logic [3:0] reg_d;
  logic [7:0] imm8;
  logic [1:0] logic_op;
  logic [1:0] trap_vec;
  logic [1:0] ext_words;
  logic block_word;
  logic branch_long;
  logic branch_take;
  logic [1:0] bit_kind;
  logic bit_inv;
  logic [2:0] bit_num;
  modport ctrl(output instr, flags, input kind, reg_a, reg_d, imm8, logic_op, trap_vec,
    ext_words, block_word, branch_long, branch_take, bit_kind, bit_inv, bit_num);
  modport dec(input instr, flags, output kind, reg_a, reg_d, imm8, logic_op, trap_vec,
    ext_words, block_word, branch_long, branch_take, bit_kind, bit_inv, bit_num);
endinterface

// ==== src/sbd_field_decode.sv ====
// Instruction field decoder and branch condition evaluator
`timescale 1ns/10ps
module sbd_field_decode (
  sbd_dec_if.dec d
);
  import sbd_pkg::*;
  wire [3:0] opf = d.instr[OPF_HI:OPF_LO];
  wire [3:0] sub = d.instr[SUB_HI:SUB_LO];
  wire fc = d.flags[FLAG_C];
  wire fv = d.flags[FLAG_V];
  wire fz = d.flags[FLAG_Z];
  wire fn = d.flags[FLAG_N];
  // Even condition codes; each odd code is the inverse of its even neighbour
  wire [7:0] cond_even = {~(fz | (fn ^ fv)), ~(fn ^ fv), ~fn, ~fv, ~fz, ~fc, ~(fc | fz), 1'b1};
  wire is_sys = (opf == OPC_SYS);
  wire is_br = (opf == OPC_BRANCH8) || (opf == OPC_BRANCH16);

  assign d.reg_a = d.instr[RA_HI:RA_LO];
  assign d.reg_d = d.instr[RD_HI:RD_LO];
  assign d.imm8 = d.instr[7:0];
  assign d.logic_op = sub[1:0];
  assign d.trap_vec = d.instr[VEC_HI:VEC_LO];
  assign d.block_word = (sub == SUB_BLK_WORD);
  assign d.branch_long = (opf == OPC_BRANCH16);
  assign d.bit_kind = d.instr[BK_HI:BK_LO];
  assign d.bit_inv = d.instr[BINV_POS];
  assign d.bit_num = d.instr[BNUM_HI:BNUM_LO];
  assign d.branch_take = is_br && (cond_even[sub[3:1]] ^ sub[0]);
  assign d.ext_words = (is_sys && sub == SUB_LDF_ABS) ? EXT_ABS_WORDS :
                       (opf == OPC_BRANCH16) ? EXT_DISP_WORDS : 2'h0;

  always_comb begin
    d.kind = K_ILLEGAL;
    if (is_br) begin
      d.kind = K_BRANCH;
    end else if (opf == OPC_BITOP) begin
      d.kind = K_BITOP;
    end else if (is_sys) begin
      case (sub)
        SUB_NO_OP: d.kind = K_NO_OP;
        SUB_TRAP: d.kind = K_TRAP;
        SUB_RETURN: d.kind = K_RETURN;
        SUB_SLEEP: d.kind = K_SLEEP;
        SUB_FLAGS_AND, SUB_FLAGS_OR, SUB_FLAGS_XOR: d.kind = K_FLAG_LOGIC;
        SUB_LDF_REG: d.kind = K_LDF_REG;
        SUB_STF_REG: d.kind = K_STF_REG;
        SUB_LDF_MEM: d.kind = K_LDF_MEM;
        SUB_STF_MEM: d.kind = K_STF_MEM;
        SUB_BLK_BYTE, SUB_BLK_WORD: d.kind = K_BLOCK;
        SUB_LDF_ABS: d.kind = K_LDF_ABS;
        default: d.kind = K_ILLEGAL;
      endcase
    end
  end
endmodule

// ==== bench/sbd_core_assertions.sv ====
// Concurrent checks on the execute unit's bus and status ports
`timescale 1ns/10ps
module sbd_core_assertions (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic mem_byte_o,
  input wire logic [sbd_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [sbd_pkg::DATA_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic sleeping_o,
  input wire logic [sbd_pkg::FLAG_W-1:0] flags_o
);
  import sbd_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable({mem_we_o, mem_byte_o, mem_addr_o});
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_align;
    mem_req_o && !mem_byte_o |-> !mem_addr_o[0];
  endproperty
  a_align: assert property (p_align) else $error("odd word address");
  property p_sleep_quiet;
    sleeping_o |-> !mem_req_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("fetch while asleep");
  property p_byte_wdata;
    mem_req_o && mem_we_o && mem_byte_o |-> mem_wdata_o[15:8] == 8'h00;
  endproperty
  a_byte_wdata: assert property (p_byte_wdata) else $error("byte write upper bits");
  property p_flag_store;
    mem_req_o && mem_we_o && !mem_byte_o |-> mem_wdata_o == {8'h00, flags_o};
  endproperty
  a_flag_store: assert property (p_flag_store) else $error("flags word write data");
  property p_rmw;
    mem_req_o && mem_ack_i && mem_byte_o && !mem_we_o
      |-> ##[1:3] (mem_req_o && mem_we_o && mem_byte_o);
  endproperty
  a_rmw: assert property (p_rmw) else $error("byte read not written back");
  property p_next_fetch;
    mem_req_o && mem_ack_i && mem_we_o && mem_byte_o |-> ##[1:3] mem_req_o;
  endproperty
  a_next_fetch: assert property (p_next_fetch) else $error("stall after byte write");
  // Only trap entry fetches from the vector area in this bench
  property p_trap_mask;
    mem_req_o && !mem_we_o && mem_addr_o >= 24'h000020 && mem_addr_o < 24'h000030
      |-> flags_o[FLAG_I];
  endproperty
  a_trap_mask: assert property (p_trap_mask) else $error("vector fetch without mask");
endmodule

// ==== bench/sbd_mem_model.sv ====
// Same-clock byte memory answering the core's bus with set wait states
`timescale 1ns/10ps
module sbd_mem_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic byte_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wait_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [7:0] mem [0:511];
  logic [2:0] rst_q;
  logic [1:0] cnt;
  logic [8:0] a;
  int n_brd = 0;
  int n_bwr = 0;
  int n_wrd = 0;
  int n_wwr = 0;
  assign a = addr_i[8:0];
  // Silent for three edges after release; idle data toggles so stale bytes never match
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 3'h0;
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= 16'h0000;
    end else begin
      rst_q <= {rst_q[1:0], 1'b1};
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o && rst_q[2]) begin
        if (cnt < wait_i) begin
          cnt <= cnt + 2'h1;
        end else begin
          cnt <= 2'h0;
          ack_o <= 1'b1;
          if (we_i && byte_i) begin
            mem[a] <= wdata_i[7:0];
            n_bwr++;
          end else if (we_i) begin
            mem[a] <= wdata_i[15:8];
            mem[a + 9'h001] <= wdata_i[7:0];
            n_wwr++;
          end else if (byte_i) begin
            rdata_o <= {8'h00, mem[a]};
            n_brd++;
          end else begin
            rdata_o <= {mem[a], mem[a + 9'h001]};
            if (!a[8]) n_wrd++;
          end
        end
      end
    end
  end
endmodule

// ==== bench/sbd_core_bench.sv ====
// Self-checking bench running a short program through the execute unit
`timescale 1ns/10ps
module sbd_core_bench;
  import sbd_pkg::*;
  localparam logic [15:0] PROG [0:35] = '{16'h0000, 16'h050F, 16'h04F5, 16'h06FF,
    16'h0400, 16'h0540, 16'h0807, 16'h0673, 16'h0A70, 16'h0400, 16'h0970, 16'h0400,
    16'h0503, 16'h0804, 16'h0653, 16'h0805, 16'h0608, 16'h0806, 16'h0B00, 16'h0C00,
    16'h7054, 16'h7451, 16'h7857, 16'h7C53, 16'h7E50, 16'h0706, 16'h0120, 16'h0504,
    16'h4704, 16'h0400, 16'h0000, 16'h0400, 16'h4704, 16'h0300, 16'h0000, 16'h40FE};
  localparam logic [7:0] BLK_DATA [0:2] = '{8'hA1, 8'hB2, 8'hC3};
  localparam logic [7:0] BIT_EXP [0:4] = '{8'h1A, 8'h18, 8'h98, 8'h90, 8'h91};
  logic core_clk_i;
  logic rst_n_i;
  logic wake_i;
  logic [1:0] wait_cycles;
  logic mem_req_o;
  logic mem_we_o;
  logic mem_byte_o;
  logic mem_ack_i;
  logic sleeping_o;
  logic [ADDR_W-1:0] mem_addr_o;
  logic [ADDR_W-1:0] pc_o;
  logic [DATA_W-1:0] mem_wdata_o;
  logic [DATA_W-1:0] mem_rdata_i;
  logic [FLAG_W-1:0] flags_o;
  int num_errors;
  int check_count;

  sbd_core sbd_core_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .wake_i(wake_i), .sleeping_o(sleeping_o), .flags_o(flags_o), .pc_o(pc_o));
  sbd_mem_model sbd_mem_model_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .req_i(mem_req_o), .we_i(mem_we_o), .byte_i(mem_byte_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .wait_i(wait_cycles), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check_flags(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Sampled mid-cycle, so effects of the previous instruction have landed
  task automatic wait_fetch(input logic [23:0] addr);
    for (int n = 0; n < 400; n++) begin
      @(negedge core_clk_i);
      if (mem_req_o === 1'b1 && mem_we_o === 1'b0 && mem_addr_o === addr
          && mem_ack_i === 1'b1) return;
    end
    num_errors++;
    $display("mismatch at %0t: no fetch at %h", $time, addr);
    end_of_test();
  endtask

  task automatic t_nop();
    wait_fetch(24'h000100);
    wait_fetch(24'h000102);
    check_val(pc_o, 24'h000102, "pc after no-op");
    check_flags(flags_o, FLAGS_RESET, "flags after no-op");
    $display("no-op test done");
  endtask

  task automatic t_flag_logic();
    wait_fetch(24'h000104);
    check_flags(flags_o, 8'h8F, "or");
    wait_fetch(24'h000106);
    check_flags(flags_o, 8'h85, "and");
    wait_fetch(24'h000108);
    check_flags(flags_o, 8'h7A, "xor");
    $display("flag logic test done");
  endtask

  task automatic t_flags_mem();
    wait_fetch(24'h000112);
    check_val(24'(sbd_mem_model_inst.n_wwr), 24'h1, "word writes");
    check_flags(sbd_mem_model_inst.mem[9'h041], 8'h33, "stored flags");
    wait_fetch(24'h000116);
    check_flags(flags_o, 8'h33, "loaded flags");
    check_val(24'(sbd_mem_model_inst.n_wrd), 24'h1, "word reads");
    $display("flags memory test done");
  endtask

  // Wait states during the copy exercise the hold side of the bus
  task automatic t_block();
    @(posedge core_clk_i);
    wait_cycles <= 2'h2;
    wait_fetch(24'h000126);
    for (int i = 0; i < 3; i++) begin
      check_flags(sbd_mem_model_inst.mem[9'h058 + i], BLK_DATA[i], "copied byte");
    end
    check_val(24'(sbd_mem_model_inst.n_brd), 24'h3, "byte reads");
    check_val(24'(sbd_mem_model_inst.n_bwr), 24'h3, "byte writes");
    wait_fetch(24'h000128);
    check_val(24'(sbd_mem_model_inst.n_brd), 24'h3, "zero count reads");
    @(posedge core_clk_i);
    wait_cycles <= 2'h0;
    $display("block copy test done");
  endtask

  task automatic t_bitop();
    for (int i = 0; i < 5; i++) begin
      wait_fetch(24'h00012A + 24'(2 * i));
      check_flags(sbd_mem_model_inst.mem[9'h053], BIT_EXP[i], "bit op byte");
    end
    check_val(24'(sbd_mem_model_inst.n_bwr), 24'h8, "bit op writes");
    $display("bit op test done");
  endtask

  task automatic t_trap();
    wait_fetch(24'h000134);
    check_flags(flags_o, 8'h5B, "register load");
    wait_fetch(24'h000028);
    check_flags(flags_o, 8'hDB, "trap flags");
    wait_fetch(24'h000136);
    check_flags(flags_o, 8'h5B, "return flags");
    $display("trap test done");
  endtask

  task automatic t_branch();
    wait_fetch(24'h00013E);
    check_val(pc_o, 24'h00013E, "taken branch");
    check_flags(flags_o, 8'h5F, "taken branch skips");
    wait_fetch(24'h000142);
    check_val(pc_o, 24'h000142, "untaken branch");
    $display("branch test done");
  endtask

  task automatic t_sleep();
    int reqs;
    reqs = 0;
    for (int n = 0; n < 50 && sleeping_o !== 1'b1; n++) @(negedge core_clk_i);
    check_val({23'h0, sleeping_o}, 24'h1, "asleep");
    repeat (20) begin
      @(negedge core_clk_i);
      if (mem_req_o !== 1'b0) reqs++;
    end
    check_val(24'(reqs), 24'h0, "requests while asleep");
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    wait_fetch(24'h000144);
    check_val({23'h0, sleeping_o}, 24'h0, "awake");
    @(posedge core_clk_i);
    wake_i <= 1'b0;
    $display("sleep test done");
  endtask

  initial begin
    rst_n_i = 1'b0;
    wake_i = 1'b0;
    wait_cycles = 2'h0;
    num_errors = 0;
    check_count = 0;
    for (int i = 0; i < 512; i++) sbd_mem_model_inst.mem[i] = 8'h00;
    for (int i = 0; i < 36; i++) begin
      sbd_mem_model_inst.mem[256 + 2 * i] = PROG[i][15:8];
      sbd_mem_model_inst.mem[257 + 2 * i] = PROG[i][7:0];
    end
    for (int i = 0; i < 3; i++) sbd_mem_model_inst.mem[80 + i] = BLK_DATA[i];
    sbd_mem_model_inst.mem[9'h028] = 8'h02;
    sbd_mem_model_inst.mem[9'h053] = 8'h0A;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_nop();
    t_flag_logic();
    t_flags_mem();
    t_block();
    t_bitop();
    t_trap();
    t_branch();
    t_sleep();
    end_of_test();
  end
endmodule

bind sbd_core sbd_core_assertions sbd_core_assertions_inst (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
  .sleeping_o(sleeping_o), .flags_o(flags_o));
